// ### common/msc_cfg.svh
// Operation
// (R1) Idle until control supply is up
// (R2) Latch lock and direction straps at start
// (R3) Command below 1.0 V keeps outputs off
// (R4) Charge range pulses low sides each PWM cycle
// (R5) Run range sets duty from command
// (R6) Trapezoidal below 1 Hz, sinusoidal at or above
// (R7) Reverse rotation forces trapezoidal within one step
// (R8) No charging when reversed or coasting fast; the code does not end a precharge for either
// (R9) Jump to run range precharges 9 ms first; the code skips it in test mode or when reversed or fast
// (R10) Duty from 7-bit code, rising monotonically
// (R11) Command at or above 5.4 V gives 100%
// (R12) Power-up straps select test mode
// (R13) Test: full duty trapezoidal, no thermal, zero advance
// (R14) Host raises command last, lowers it first
// (R15) Host applies main supply within lock time
// (R16) No position change for lock time: lock fault
// (R17) Direction tracked after start, lock setting kept
// (R18) Code thresholds stand for 1.0, 2.1, 5.4 V
`ifndef MSC_CFG_SVH
`define MSC_CFG_SVH

// Speed command codes at 10 V full scale, 78.125 mV per step
`define MSC_CODE_CHG 7'h0d
`define MSC_CODE_RUN 7'h1b
`define MSC_CODE_FULL 7'h45
`define MSC_CODE_TEST 7'h68
// Advance input window around 2.75 V
`define MSC_ADV_TEST_LO 7'h21
`define MSC_ADV_TEST_HI 7'h25
`define MSC_DUTY_GAIN 7'h03
`define MSC_DUTY_MAX 7'h7f

// Timing
`define MSC_CLK_MHZ 250
`define MSC_PRECHG_US 9000
`define MSC_PRECHG_CYC (`MSC_PRECHG_US * `MSC_CLK_MHZ)
`define MSC_SINE_HZ 1
`define MSC_SINE_CYC ((`MSC_CLK_MHZ * 1000000) / `MSC_SINE_HZ)
`define MSC_STEP_CYC (`MSC_SINE_CYC / 6)
`define MSC_LOCK_MS 1000
`define MSC_LOCK_CYC (`MSC_LOCK_MS * `MSC_CLK_MHZ * 1000)
`define MSC_CHG_ON_CYC 7'h10

// Register offsets
`define MSC_REG_CTRL 8'h00
`define MSC_REG_STATUS 8'h04
`define MSC_REG_IRQ_STAT 8'h08
`define MSC_REG_IRQ_MASK 8'h0c
`define MSC_REG_DUTY 8'h10
`define MSC_CTRL_RESET 1'b1
`define MSC_IRQ_MASK_RESET 4'h0

`endif

// ### common/msc_pkg.sv
package msc_pkg;

    typedef enum logic [5:0] {
        MSC_ST_OFF = 6'h01,
        MSC_ST_LATCH = 6'h02,
        MSC_ST_IDLE = 6'h04,
        MSC_ST_CHARGE = 6'h08,
        MSC_ST_PRECHG = 6'h10,
        MSC_ST_RUN = 6'h20
    } msc_state_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic we;
        logic re;
    } msc_req_s;

    typedef struct packed {
        logic fast;
        logic reverse;
        logic locked;
    } msc_hall_s;

    // Irq bits: lock, reverse, sine entry, supply loss
    typedef struct packed {
        logic supply_lost;
        logic sine_on;
        logic reverse;
        logic lock;
    } msc_irq_s;

endpackage

// ### src/msc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module msc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level_q
);
    // Level taken once stages two and three agree
    genvar i;
    for (i = 0; i < WIDTH; i++) begin : g_bit
        logic s1_q;
        logic s2_q;
        logic s3_q;
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                s1_q <= 1'b0;
                s2_q <= 1'b0;
                s3_q <= 1'b0;
                level_q[i] <= 1'b0;
            end else if (clk_en) begin
                s1_q <= pin[i];
                s2_q <= s1_q;
                s3_q <= s2_q;
                if (s2_q == s3_q) begin
                    level_q[i] <= s3_q;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### src/msc_hall_mon.sv
`timescale 1ns/1ps
`default_nettype none
module msc_hall_mon
    import msc_pkg::*;
#(
    parameter int STEP_CYC = 41666666,
    parameter int LOCK_CYC = 250000000
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [2:0] hall,
    input wire logic dir_fwd,
    input wire logic restart,
    output msc_hall_s mon_q
);
    logic [2:0] hall_q;
    logic [2:0] sec_new;
    logic [2:0] sec_old;
    logic [2:0] sec_next;
    logic [2:0] sec_prev;
    logic [27:0] step_cnt_q;
    logic [27:0] lock_cnt_q;
    logic changed;
    logic fwd_step;
    logic rev_step;

    // Forward sector order of the position code
    function automatic logic [2:0] sector(input logic [2:0] h);
        case (h)
            3'h5: sector = 3'h0;
            3'h4: sector = 3'h1;
            3'h6: sector = 3'h2;
            3'h2: sector = 3'h3;
            3'h3: sector = 3'h4;
            3'h1: sector = 3'h5;
            default: sector = 3'h7;
        endcase
    endfunction

    assign sec_new = sector(hall);
    assign sec_old = sector(hall_q);
    assign sec_next = (sec_old == 3'h5) ? 3'h0 : sec_old + 3'h1;
    assign sec_prev = (sec_old == 3'h0) ? 3'h5 : sec_old - 3'h1;
    assign changed = hall != hall_q;
    assign fwd_step = changed && sec_old != 3'h7 && sec_new == sec_next;
    assign rev_step = changed && sec_old != 3'h7 && sec_new == sec_prev;

    // Step interval sets the fast flag; counters saturate
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hall_q <= 3'h0;
            step_cnt_q <= 28'h0;
            mon_q.fast <= 1'b0;
        end else if (clk_en) begin
            hall_q <= hall;
            if (changed) begin
                step_cnt_q <= 28'h0;
                mon_q.fast <= step_cnt_q < 28'(STEP_CYC); // R6
            end else if (step_cnt_q != 28'hfffffff) begin
                step_cnt_q <= step_cnt_q + 28'h1;
                if (step_cnt_q >= 28'(STEP_CYC)) begin
                    mon_q.fast <= 1'b0; // R6
                end
            end
        end
    end

    // Wrong-way step flags reverse within one 60 degree step
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mon_q.reverse <= 1'b0;
        end else if (clk_en) begin
            if (dir_fwd ? rev_step : fwd_step) begin
                mon_q.reverse <= 1'b1; // R7
            end else if (dir_fwd ? fwd_step : rev_step) begin
                mon_q.reverse <= 1'b0;
            end
        end
    end

    // Lock timer restarts on any change or a new start
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lock_cnt_q <= 28'h0;
            mon_q.locked <= 1'b0;
        end else if (clk_en) begin
            if (changed || restart) begin
                lock_cnt_q <= 28'h0;
                mon_q.locked <= 1'b0;
            end else if (lock_cnt_q >= 28'(LOCK_CYC)) begin
                mon_q.locked <= 1'b1; // R16
            end else begin
                lock_cnt_q <= lock_cnt_q + 28'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ### src/msc_top.sv
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "msc_cfg.svh"
module msc_top
    import msc_pkg::*;
#(
    parameter int PRECHG_CYC = `MSC_PRECHG_CYC,
    parameter int STEP_CYC = `MSC_STEP_CYC,
    parameter int LOCK_CYC = `MSC_LOCK_CYC
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic supply_ok,
    input wire logic lock_protect_select,
    input wire logic direction_select,
    input wire logic [2:0] position_sense,
    input wire logic [6:0] speed_code,
    input wire logic [6:0] advance_code,
    input wire msc_req_s bus_req,
    output logic [31:0] bus_rdata_q,
    output logic irq_q,
    output logic hs_pwm_q,
    output logic ls_charge_q,
    output logic sine_mode_q,
    output logic reverse_q,
    output logic lock_fault_q,
    output logic fault_q,
    output logic tsd_enable_q,
    output logic [6:0] advance_angle_q,
    output logic [6:0] duty_q
);
    msc_state_e state_q;
    msc_state_e state_d;
    msc_hall_s mon;
    msc_irq_s irq_stat_q;
    msc_irq_s irq_mask_q;
    msc_irq_s events;
    logic [5:0] pins_s;
    logic supply_s;
    logic mlp_s;
    logic dir_s;
    logic [2:0] hall_s;
    logic lock_en_q;
    logic dir_fwd_q;
    logic test_q;
    logic run_en_q;
    logic [22:0] prechg_cnt_q;
    logic prechg_done;
    logic [6:0] pwm_cnt_q;
    logic [6:0] duty_d;
    logic [6:0] code_off;
    logic skip_chg;
    logic in_run;
    logic reverse_d1_q;
    logic sine_d1_q;
    logic lock_d1_q;
    logic supply_d1_q;
    logic rd_irq;

    // Pin inputs share one synchroniser bank
    msc_sync #(
        .WIDTH(6)
    ) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .pin({supply_ok, lock_protect_select, direction_select, position_sense}),
        .level_q(pins_s)
    );

    assign supply_s = pins_s[5];
    assign mlp_s = pins_s[4];
    assign dir_s = pins_s[3];
    assign hall_s = pins_s[2:0];

    msc_hall_mon #(
        .STEP_CYC(STEP_CYC),
        .LOCK_CYC(LOCK_CYC)
    ) u_hall (
        .clock(clock),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .hall(hall_s),
        .dir_fwd(dir_fwd_q),
        .restart(state_q != MSC_ST_RUN),
        .mon_q(mon)
    );

    // No charging outside precharge while reversed or coasting fast
    assign skip_chg = mon.reverse || mon.fast; // R8
    assign prechg_done = prechg_cnt_q >= 23'(PRECHG_CYC - 1);
    assign in_run = state_q == MSC_ST_RUN;

    // Startup sequencer
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            MSC_ST_OFF: begin
                if (supply_s) begin
                    state_d = MSC_ST_LATCH; // R1
                end
            end
            MSC_ST_LATCH: begin
                state_d = MSC_ST_IDLE;
            end
            MSC_ST_IDLE: begin
                if (!run_en_q) begin
                    state_d = MSC_ST_IDLE;
                end else if (speed_code >= `MSC_CODE_RUN) begin // R18
                    // Sudden jump still charges first unless skipping or in test mode
                    state_d = (skip_chg || test_q) ? MSC_ST_RUN : MSC_ST_PRECHG; // R9
                end else if (speed_code >= `MSC_CODE_CHG && !skip_chg) begin
                    state_d = MSC_ST_CHARGE; // R4
                end
            end
            MSC_ST_CHARGE: begin
                if (!run_en_q || speed_code < `MSC_CODE_CHG || skip_chg) begin
                    state_d = MSC_ST_IDLE; // R3
                end else if (speed_code >= `MSC_CODE_RUN) begin
                    state_d = MSC_ST_RUN; // R5
                end
            end
            MSC_ST_PRECHG: begin
                if (!run_en_q || speed_code < `MSC_CODE_CHG) begin
                    state_d = MSC_ST_IDLE;
                end else if (prechg_done) begin
                    state_d = MSC_ST_RUN; // R9
                end
            end
            MSC_ST_RUN: begin
                if (!run_en_q || speed_code < `MSC_CODE_RUN) begin
                    state_d = MSC_ST_IDLE; // R3
                end
            end
        endcase
        if (!supply_s) begin
            state_d = MSC_ST_OFF; // R1
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= MSC_ST_OFF;
        end else if (clk_en) begin
            state_q <= state_d;
        end
    end

    // Precharge timer, cleared outside its state
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prechg_cnt_q <= 23'h0;
        end else if (clk_en) begin
            if (state_q == MSC_ST_PRECHG) begin
                prechg_cnt_q <= prechg_cnt_q + 23'h1; // R9
            end else begin
                prechg_cnt_q <= 23'h0;
            end
        end
    end

    // Straps: lock frozen at start, direction tracked
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lock_en_q <= 1'b0;
            dir_fwd_q <= 1'b1;
            test_q <= 1'b0;
        end else if (clk_en) begin
            if (state_q == MSC_ST_LATCH) begin
                lock_en_q <= !mlp_s; // R2
                dir_fwd_q <= dir_s; // R2
                test_q <= speed_code >= `MSC_CODE_TEST &&
                    advance_code >= `MSC_ADV_TEST_LO &&
                    advance_code <= `MSC_ADV_TEST_HI; // R12
            end else if (state_q != MSC_ST_OFF) begin
                dir_fwd_q <= dir_s; // R17
            end
        end
    end

    // Duty from the converted code; saturates at full scale
    always_comb begin
        code_off = speed_code - `MSC_CODE_RUN;
        if (speed_code >= `MSC_CODE_FULL || test_q) begin
            duty_d = `MSC_DUTY_MAX; // R11 R13
        end else if (speed_code < `MSC_CODE_RUN) begin
            duty_d = 7'h00;
        end else begin
            duty_d = 7'(code_off * `MSC_DUTY_GAIN); // R10
        end
    end

    // PWM carrier; one period is one charge opportunity
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pwm_cnt_q <= 7'h00;
        end else if (clk_en) begin
            pwm_cnt_q <= pwm_cnt_q + 7'h01;
        end
    end

    // Gate outputs; max duty must mean always on, not 127 of 128
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hs_pwm_q <= 1'b0;
            ls_charge_q <= 1'b0;
            duty_q <= 7'h00;
        end else if (clk_en) begin
            duty_q <= in_run ? duty_d : 7'h00; // R5
            hs_pwm_q <= in_run && !lock_fault_q &&
                (duty_d == `MSC_DUTY_MAX || pwm_cnt_q < duty_d); // R5 R11
            ls_charge_q <= (state_q == MSC_ST_CHARGE || state_q == MSC_ST_PRECHG)
                && pwm_cnt_q < `MSC_CHG_ON_CYC; // R4
        end
    end

    // Drive mode and protection outputs
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sine_mode_q <= 1'b0;
            reverse_q <= 1'b0;
            lock_fault_q <= 1'b0;
            fault_q <= 1'b0;
            tsd_enable_q <= 1'b1;
            advance_angle_q <= 7'h00;
        end else if (clk_en) begin
            // Reverse drops sine at once; test stays trapezoidal
            sine_mode_q <= in_run && mon.fast && !mon.reverse && !test_q; // R6 R7 R13
            reverse_q <= mon.reverse;
            if (!in_run) begin
                lock_fault_q <= 1'b0;
            end else if (lock_en_q && mon.locked) begin
                lock_fault_q <= 1'b1; // R16
            end
            fault_q <= (in_run && lock_en_q && mon.locked) || mon.reverse;
            tsd_enable_q <= !test_q; // R13
            advance_angle_q <= test_q ? 7'h00 : advance_code; // R13
        end
    end

    // Edge history for interrupt events
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reverse_d1_q <= 1'b0;
            sine_d1_q <= 1'b0;
            lock_d1_q <= 1'b0;
            supply_d1_q <= 1'b0;
        end else if (clk_en) begin
            reverse_d1_q <= reverse_q;
            sine_d1_q <= sine_mode_q;
            lock_d1_q <= lock_fault_q;
            supply_d1_q <= supply_s;
        end
    end

    assign events.lock = lock_fault_q && !lock_d1_q;
    assign events.reverse = reverse_q && !reverse_d1_q;
    assign events.sine_on = sine_mode_q && !sine_d1_q;
    assign events.supply_lost = supply_d1_q && !supply_s;
    assign rd_irq = bus_req.re && bus_req.addr == `MSC_REG_IRQ_STAT;

    // Sticky status, read clears, a same-cycle event survives
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_q <= '0;
            irq_q <= 1'b0;
        end else if (clk_en) begin
            irq_stat_q <= (rd_irq ? msc_irq_s'(4'h0) : irq_stat_q) | events;
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    // Register writes
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            run_en_q <= `MSC_CTRL_RESET;
            irq_mask_q <= `MSC_IRQ_MASK_RESET;
        end else if (clk_en && bus_req.we) begin
            if (bus_req.addr == `MSC_REG_CTRL) begin
                run_en_q <= bus_req.wdata[0];
            end
            if (bus_req.addr == `MSC_REG_IRQ_MASK) begin
                irq_mask_q <= bus_req.wdata[3:0];
            end
        end
    end

    // Read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bus_rdata_q <= 32'h0;
        end else if (clk_en) begin
            bus_rdata_q <= 32'h0;
            if (bus_req.re) begin
                case (bus_req.addr)
                    `MSC_REG_CTRL: bus_rdata_q <= {31'h0, run_en_q};
                    `MSC_REG_STATUS: bus_rdata_q <= {16'h0, 2'h0, state_q,
                        test_q, lock_en_q, dir_fwd_q, lock_fault_q,
                        mon.locked, mon.reverse, mon.fast, sine_mode_q};
                    `MSC_REG_IRQ_STAT: bus_rdata_q <= {28'h0, irq_stat_q};
                    `MSC_REG_IRQ_MASK: bus_rdata_q <= {28'h0, irq_mask_q};
                    `MSC_REG_DUTY: bus_rdata_q <= {25'h0, duty_q};
                    default: bus_rdata_q <= 32'h0;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ### sim/msc_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module msc_top_assertions
    import msc_pkg::*;
#(
    parameter int LOCK_CYC = 250000000
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic supply_ok,
    input wire logic [2:0] position_sense,
    input wire logic [6:0] speed_code,
    input wire msc_req_s bus_req,
    input wire logic [31:0] bus_rdata_q,
    input wire logic hs_pwm_q,
    input wire logic ls_charge_q,
    input wire logic sine_mode_q,
    input wire logic reverse_q,
    input wire logic lock_fault_q,
    input wire logic fault_q,
    input wire logic tsd_enable_q,
    input wire logic [6:0] advance_angle_q,
    input wire logic [6:0] duty_q
);
    logic [2:0] hall_q;
    logic [31:0] still_q;
    logic [7:0] ls_run_q;

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    // Raw sensor idle time, never below the design's count; charge pulse length
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hall_q <= 3'h0;
            still_q <= 32'h0;
            ls_run_q <= 8'h0;
        end else begin
            hall_q <= position_sense;
            still_q <= (position_sense != hall_q) ? 32'h0 : still_q + 32'h1;
            ls_run_q <= ls_charge_q ? ls_run_q + 8'h1 : 8'h0;
        end
    end

    sequence s_code_held;
        $stable(speed_code) [*4];
    endsequence
    sequence s_supply_gone;
        !supply_ok [*8];
    endsequence

    a_off_no_gate: assert property (s_supply_gone |-> !hs_pwm_q && !ls_charge_q)
        else $error("gates on, no supply");
    a_low_cmd_off: assert property ((speed_code < 7'h0d) [*6] |-> !hs_pwm_q && !ls_charge_q)
        else $error("gates on, low command");
    a_duty_map: assert property (s_code_held ##0 (duty_q != 7'h00 && tsd_enable_q)
        |-> duty_q == ((speed_code >= 7'h45) ? 7'h7f : (speed_code - 7'h1b) * 7'h03))
        else $error("duty mismatch");
    a_full_on: assert property ((duty_q == 7'h7f) [*2] |-> hs_pwm_q)
        else $error("high side off at full duty");
    a_test_fixed: assert property (!tsd_enable_q |-> advance_angle_q == 7'h00 && !sine_mode_q)
        else $error("test mode settings");
    a_reverse_trap: assert property ($rose(reverse_q) |-> ##[0:2] !sine_mode_q)
        else $error("sine after reverse");
    a_fault_follow: assert property (reverse_q || lock_fault_q |-> ##[0:2] fault_q)
        else $error("no fault");
    a_lock_wait: assert property ($rose(lock_fault_q) |-> still_q >= 32'(LOCK_CYC))
        else $error("early lock");
    a_charge_width: assert property (ls_charge_q |-> ls_run_q < 8'd16)
        else $error("charge pulse too long");
    a_rdata_idle: assert property (!bus_req.re |=> bus_rdata_q == 32'h0)
        else $error("stray read data");
endmodule

bind msc_top msc_top_assertions #(.LOCK_CYC(LOCK_CYC)) i_chk (
    .clock, .rst_n, .supply_ok, .position_sense, .speed_code, .bus_req, .bus_rdata_q,
    .hs_pwm_q, .ls_charge_q, .sine_mode_q, .reverse_q, .lock_fault_q, .fault_q,
    .tsd_enable_q, .advance_angle_q, .duty_q
);
`default_nettype wire

// ### sim/msc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module msc_host_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic power,
    input wire logic strap,
    input wire logic [6:0] cmd,
    input wire logic spin,
    input wire logic [7:0] step_cyc,
    output logic supply_ok,
    output logic [6:0] speed_code,
    output logic [6:0] advance_code,
    output logic [2:0] position_sense
);
    localparam logic [2:0] HALL_SEQ [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
    logic [3:0] up_q;
    logic [2:0] idx_q;
    logic [7:0] cnt_q;

    // Advance inside the test window only for test strap
    assign advance_code = strap ? 7'h23 : 7'h10;
    assign position_sense = HALL_SEQ[idx_q];

    // Command up last, down first, unless strapped
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            supply_ok <= 1'b0;
            speed_code <= 7'h00;
            up_q <= 4'h0;
        end else if (power) begin
            supply_ok <= 1'b1;
            up_q <= (up_q == 4'hf) ? up_q : up_q + 4'h1;
            speed_code <= (strap || up_q == 4'hf) ? cmd : 7'h00;
        end else begin
            up_q <= 4'h0;
            speed_code <= strap ? cmd : 7'h00;
            supply_ok <= supply_ok && !strap && speed_code != 7'h00;
        end
    end

    // Forward step every step_cyc+1 cycles
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            idx_q <= 3'd0;
            cnt_q <= 8'h00;
        end else if (spin && cnt_q >= step_cyc) begin
            cnt_q <= 8'h00;
            idx_q <= (idx_q == 3'd5) ? 3'd0 : idx_q + 3'd1;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ### sim/msc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module msc_top_test import msc_pkg::*;;
    logic clock = 1'b0, rst_n = 1'b0, lock_sel = 1'b0, pwr = 1'b0, strap = 1'b0, spin = 1'b0;
    logic clk_en = 1'b1, dir_sel = 1'b1;
    logic [6:0] cmd = 7'h00;
    logic [7:0] step = 8'd80;
    msc_req_s bus_req = '0;
    logic supply_ok, irq_q, hs_pwm_q, ls_charge_q, sine_mode_q, reverse_q;
    logic lock_fault_q, fault_q, tsd_enable_q;
    logic [2:0] position_sense;
    logic [6:0] speed_code, advance_code, advance_angle_q, duty_q;
    logic [31:0] bus_rdata_q, rd;
    int num_errors = 0, total_checks = 0, cyc = 0, n;

    msc_host_model i_host (
        .clock, .rst_n, .power(pwr), .strap, .cmd, .spin, .step_cyc(step),
        .supply_ok, .speed_code, .advance_code, .position_sense
    );
    msc_top #(.PRECHG_CYC(100), .STEP_CYC(50), .LOCK_CYC(400)) i_dut (
        .clock, .rst_n, .clk_en, .supply_ok, .lock_protect_select(lock_sel),
        .direction_select(dir_sel), .position_sense, .speed_code, .advance_code,
        .bus_req, .bus_rdata_q, .irq_q, .hs_pwm_q, .ls_charge_q, .sine_mode_q, .reverse_q,
        .lock_fault_q, .fault_q, .tsd_enable_q, .advance_angle_q, .duty_q
    );

    // 250 MHz
    always #2 clock = ~clock;

    // Ceiling well above run length
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            num_errors++;
            results();
        end
    end

    task results();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %0h exp %0h", $time, got, exp);
        end
    endtask

    task ticks(input int k);
        repeat (k) @(posedge clock);
    endtask

    task bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge clock);
        bus_req <= '0;
    endtask

    // Data stand only in the cycle after the strobe
    task bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        bus_req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clock);
        bus_req <= '0;
        #1 d = bus_rdata_q;
    endtask

    task wait_st(input logic [5:0] st);
        rd = '0;
        for (int i = 0; i < 300 && rd[13:8] !== st; i++) bus_rd(8'h04, rd);
        check(rd[13:8], st);
    endtask

    // Counts high cycles of one gate output
    task count_on(input int k, input logic hs, output int c);
        c = 0;
        repeat (k) begin
            @(posedge clock);
            c += hs ? hs_pwm_q : ls_charge_q;
        end
    endtask

    task boot(input logic [6:0] c, input logic s, input logic l);
        pwr <= 1'b0;
        ticks(20);
        strap <= s;
        lock_sel <= l;
        cmd <= c;
        ticks(4);
        pwr <= 1'b1;
    endtask

    task t_reset();
        check({hs_pwm_q, ls_charge_q, irq_q, tsd_enable_q, duty_q}, 32'h080);
        bus_rd(8'h00, rd);
        check(rd, 32'h1);
        bus_rd(8'h0c, rd);
        check(rd, 32'h0);
        bus_wr(8'h0c, 32'hff);
        bus_rd(8'h0c, rd);
        check(rd, 32'hf);
        bus_wr(8'h14, 32'h5);
        bus_rd(8'h14, rd);
        check(rd, 32'h0);
        bus_rd(8'h04, rd);
        check(rd[13:8], 6'h01);
        bus_wr(8'h0c, 32'h0);
    endtask

    task t_start();
        boot(7'h0c, 1'b0, 1'b0);
        wait_st(6'h04);
        check(rd[6:5], 2'b11);
        count_on(64, 1'b1, n);
        check(n, 0);
        dir_sel <= 1'b0;
        ticks(8);
        bus_rd(8'h04, rd);
        check(rd[5], 1'b0);
        dir_sel <= 1'b1;
    endtask

    task t_charge();
        cmd <= 7'h0d;
        wait_st(6'h08);
        count_on(256, 1'b0, n);
        check(n, 32);
        cmd <= 7'h30;
        wait_st(6'h20);
    endtask

    task automatic t_duty();
        logic [6:0] codes [6] = '{7'h1b, 7'h1c, 7'h2a, 7'h44, 7'h45, 7'h7f};
        foreach (codes[i]) begin
            cmd <= codes[i];
            ticks(6);
            check(duty_q, codes[i] >= 7'h45 ? 7'h7f : (codes[i] - 7'h1b) * 7'h03);
        end
        count_on(128, 1'b1, n);
        check(n, 128);
        bus_rd(8'h10, rd);
        check(rd, 32'h7f);
        check(advance_angle_q, 7'h10);
    endtask

    task t_prechg();
        boot(7'h30, 1'b0, 1'b0);
        for (n = 0; n < 200 && speed_code < 7'h1b; n++) @(posedge clock);
        for (n = 0; n < 300 && duty_q === 7'h00; n++) @(posedge clock);
        check(n >= 95 && n <= 106, 1'b1);
    endtask

    task t_spin();
        bus_wr(8'h0c, 32'h4);
        spin <= 1'b1;
        ticks(600);
        check(sine_mode_q, 1'b0);
        step <= 8'd20;
        ticks(200);
        check(sine_mode_q, 1'b1);
        check(irq_q, 1'b1);
        bus_rd(8'h08, rd);
        check(rd[2], 1'b1);
        ticks(2);
        check(irq_q, 1'b0);
        dir_sel <= 1'b0;
        ticks(60);
        check({reverse_q, sine_mode_q, fault_q}, 3'b101);
        cmd <= 7'h10;
        wait_st(6'h04);
        count_on(256, 1'b0, n);
        check(n, 0);
        dir_sel <= 1'b1;
        ticks(60);
        check(reverse_q, 1'b0);
        count_on(256, 1'b0, n);
        check(n, 0);
        spin <= 1'b0;
        cmd <= 7'h0c;
    endtask

    task t_lock();
        bus_wr(8'h0c, 32'h1);
        cmd <= 7'h30;
        wait_st(6'h20);
        for (n = 0; n < 800 && lock_fault_q !== 1'b1; n++) @(posedge clock);
        ticks(2);
        check({lock_fault_q, fault_q, irq_q}, 3'b111);
        boot(7'h30, 1'b0, 1'b1);
        wait_st(6'h20);
        check(rd[6], 1'b0);
        ticks(600);
        check(lock_fault_q, 1'b0);
    endtask

    task t_ctrl();
        bus_wr(8'h00, 32'h0);
        ticks(4);
        check({hs_pwm_q, duty_q}, 8'h00);
        wait_st(6'h04);
        bus_wr(8'h00, 32'h1);
    endtask

    task t_test();
        boot(7'h68, 1'b1, 1'b0);
        wait_st(6'h20);
        check(rd[7], 1'b1);
        step <= 8'd20;
        spin <= 1'b1;
        ticks(300);
        check({tsd_enable_q, sine_mode_q, advance_angle_q, duty_q}, 16'h007f);
        count_on(128, 1'b1, n);
        check(n, 128);
        spin <= 1'b0;
    endtask

    // Reset, then scenarios
    initial begin
        ticks(10);
        rst_n <= 1'b1;
        t_reset();
        t_start();
        t_charge();
        t_duty();
        t_prechg();
        t_spin();
        t_lock();
        t_ctrl();
        t_test();
        results();
    end
endmodule
`default_nettype wire
